// ===== src/blgc_config.v
// Lane mapping and general configuration registers with per-link copies.
`timescale 1ns/1ns
`include "blgc_regs.vh"
module blgc_config (
   // Clock and reset
   input  wire       i_clk,
   input  wire       i_srst,
   // Register access from the I2C target logic
   input  wire       i_reg_wr,
   input  wire [7:0] i_reg_addr,
   input  wire [7:0] i_reg_wdata,
   input  wire       i_second_link_select,
   output reg  [7:0] o_reg_rdata,
   // Port A lanes: data lanes 3..0 and clock, as p/n pairs
   input  wire [3:0] i_a_data_p,
   input  wire [3:0] i_a_data_n,
   input  wire       i_a_clk_p,
   input  wire       i_a_clk_n,
   output wire [3:0] o_a_data_p,
   output wire [3:0] o_a_data_n,
   output wire       o_a_clk_p,
   output wire       o_a_clk_n,
   // Port B lanes
   input  wire [3:0] i_b_data_p,
   input  wire [3:0] i_b_data_n,
   input  wire       i_b_clk_p,
   input  wire       i_b_clk_n,
   output wire [3:0] o_b_data_p,
   output wire [3:0] o_b_data_n,
   output wire       o_b_clk_p,
   output wire       o_b_clk_n,
   // Sync inputs on the pixel clock enable
   input  wire       i_pclk_en,
   input  wire [2:0] i_sync,
   output reg  [2:0] o_sync,
   // Pixel clock presence and clock selection
   input  wire       i_pclk_present,
   output wire       o_use_always_on_clk,
   // Control levels to the rest of the device
   output wire       o_crc_check_enable,
   output wire       o_pin_pulldown_off,
   output wire [1:0] o_auto_ack,
   output wire [1:0] o_pass_through,
   output wire       o_crc_count_clear,
   output wire [1:0] o_fwd_check_override_enable,
   output wire [1:0] o_fwd_check_override_value
);

   // Shared register bits. The per-link bits of the general registers are
   // not kept here; they live in the per-link copies further down.
   reg  [7:0] lane_q;
   reg  [7:0] lane_d;
   reg  [7:0] gen_q;
   reg  [7:0] gen_d;
   reg        crc_clr_q;
   reg        crc_clr_d;

   // Per-link copies, bit 1 for the second link.
   wire [1:0] ack_w;
   wire [1:0] pass_w;
   wire [1:0] ov_en_w;
   wire [1:0] ov_val_w;

   // Synchronisers and the sync pulse filter.
   reg  [1:0] pres_meta_q;
   reg  [2:0] sync_meta_q;
   reg  [2:0] sync_s_q;
   reg  [2:0] sync_prev_q;
   reg  [2:0] sync_stable_q;
   wire [2:0] sync_d;

   // Write strobes and the link that the per-link fields address.
   wire       sel;
   wire       wr_lane;
   wire       wr_gen;
   wire       wr_gen2;

   genvar     gv_link;
   genvar     gv_lane;
   genvar     gv_sync;

   // True when the offset on the register bus is the given one. All write
   // strobes use it, so a change of decoding has one place to go.
   function addr_hit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         addr_hit = (addr == offset);
      end
   endfunction

   // One leg of a differential pair, crossed over when swap is set.
   function pick_leg;
      input swap;
      input leg_p;
      input leg_n;
      begin
         pick_leg = swap ? leg_n : leg_p;
      end
   endfunction

   assign sel = i_second_link_select;

   assign wr_lane = i_reg_wr &&
      addr_hit(i_reg_addr, `BLGC_ADDR_LANE);
   assign wr_gen = i_reg_wr &&
      addr_hit(i_reg_addr, `BLGC_ADDR_GEN);
   assign wr_gen2 = i_reg_wr &&
      addr_hit(i_reg_addr, `BLGC_ADDR_GEN2);

   // Lane mapping register.
   always @* begin
      lane_d = lane_q;
      if (wr_lane) begin
         lane_d = i_reg_wdata & `BLGC_MASK_LANE;
      end
   end

   always @(posedge i_clk) begin
      if (i_srst) begin
         lane_q <= `BLGC_RST_LANE;
      end else begin
         lane_q <= lane_d;
      end
   end

   // General register, shared bits only.
   always @* begin
      gen_d = gen_q;
      if (wr_gen) begin
         gen_d = i_reg_wdata & `BLGC_MASK_GEN;
      end
   end

   always @(posedge i_clk) begin
      if (i_srst) begin
         gen_q <= `BLGC_RST_GEN & `BLGC_MASK_GEN;
      end else begin
         gen_q <= gen_d;
      end
   end

   // Counter clear is a plain level; software must write it back to zero.
   always @* begin
      crc_clr_d = crc_clr_q;
      if (wr_gen2) begin
         crc_clr_d = i_reg_wdata[`BLGC_BIT_CRC_CLR];
      end
   end

   always @(posedge i_clk) begin
      if (i_srst) begin
         crc_clr_q <= 1'b0;
      end else begin
         crc_clr_q <= crc_clr_d;
      end
   end

   // Each link keeps its own copy of the per-link bits. The select is
   // sampled at the write, so moving it later does not disturb a copy.
   generate
      for (gv_link = 0; gv_link < 2; gv_link = gv_link + 1) begin : g_link
         wire mine;
         reg  ack_q;
         reg  pass_q;
         reg  ov_en_q;
         reg  ov_val_q;

         assign mine = (gv_link == 1) ? sel : !sel;

         always @(posedge i_clk) begin
            if (i_srst) begin
               ack_q <= 1'b0;
               pass_q <= 1'b0;
               ov_en_q <= 1'b0;
               ov_val_q <= 1'b0;
            end else begin
               if (wr_gen && mine) begin
                  ack_q <= i_reg_wdata[`BLGC_BIT_AUTO_ACK];
                  pass_q <= i_reg_wdata[`BLGC_BIT_PASS];
               end
               if (wr_gen2 && mine) begin
                  ov_en_q <= i_reg_wdata[`BLGC_BIT_OV_EN];
                  ov_val_q <= i_reg_wdata[`BLGC_BIT_OV_VAL];
               end
            end
         end

         assign ack_w[gv_link] = ack_q;
         assign pass_w[gv_link] = pass_q;
         assign ov_en_w[gv_link] = ov_en_q;
         assign ov_val_w[gv_link] = ov_val_q;
      end
   endgenerate

   // Reads are combinational; unmapped offsets and reserved bits give zero.
   always @* begin
      o_reg_rdata = 8'h00;
      case (i_reg_addr)
         `BLGC_ADDR_LANE: begin
            o_reg_rdata = lane_q;
         end
         `BLGC_ADDR_GEN: begin
            o_reg_rdata = gen_q;
            o_reg_rdata[`BLGC_BIT_AUTO_ACK] = ack_w[sel];
            o_reg_rdata[`BLGC_BIT_PASS] = pass_w[sel];
         end
         `BLGC_ADDR_GEN2: begin
            o_reg_rdata[`BLGC_BIT_CRC_CLR] = crc_clr_q;
            o_reg_rdata[`BLGC_BIT_OV_EN] = ov_en_w[sel];
            o_reg_rdata[`BLGC_BIT_OV_VAL] = ov_val_w[sel];
         end
         default: begin
            o_reg_rdata = 8'h00;
         end
      endcase
   end

   // Lane remap. Swap and flip act on the lane wires directly, so they add
   // no delay; with the flip set, output lane k is fed from input lane 3-k.
   generate
      for (gv_lane = 0; gv_lane < 4; gv_lane = gv_lane + 1) begin : g_lane
         wire a_src_p;
         wire a_src_n;
         wire b_src_p;
         wire b_src_n;

         assign a_src_p = lane_q[`BLGC_BIT_A_FLIP] ?
            i_a_data_p[3 - gv_lane] : i_a_data_p[gv_lane];
         assign a_src_n = lane_q[`BLGC_BIT_A_FLIP] ?
            i_a_data_n[3 - gv_lane] : i_a_data_n[gv_lane];
         assign b_src_p = lane_q[`BLGC_BIT_B_FLIP] ?
            i_b_data_p[3 - gv_lane] : i_b_data_p[gv_lane];
         assign b_src_n = lane_q[`BLGC_BIT_B_FLIP] ?
            i_b_data_n[3 - gv_lane] : i_b_data_n[gv_lane];

         assign o_a_data_p[gv_lane] = pick_leg(
            lane_q[`BLGC_BIT_A_DATA_SWAP], a_src_p, a_src_n);
         assign o_a_data_n[gv_lane] = pick_leg(
            lane_q[`BLGC_BIT_A_DATA_SWAP], a_src_n, a_src_p);
         assign o_b_data_p[gv_lane] = pick_leg(
            lane_q[`BLGC_BIT_B_DATA_SWAP], b_src_p, b_src_n);
         assign o_b_data_n[gv_lane] = pick_leg(
            lane_q[`BLGC_BIT_B_DATA_SWAP], b_src_n, b_src_p);
      end
   endgenerate

   assign o_a_clk_p = pick_leg(lane_q[`BLGC_BIT_A_CLK_SWAP],
      i_a_clk_p, i_a_clk_n);
   assign o_a_clk_n = pick_leg(lane_q[`BLGC_BIT_A_CLK_SWAP],
      i_a_clk_n, i_a_clk_p);
   assign o_b_clk_p = pick_leg(lane_q[`BLGC_BIT_B_CLK_SWAP],
      i_b_clk_p, i_b_clk_n);
   assign o_b_clk_n = pick_leg(lane_q[`BLGC_BIT_B_CLK_SWAP],
      i_b_clk_n, i_b_clk_p);

   // Control levels to the rest of the device.
   assign o_crc_check_enable = gen_q[`BLGC_BIT_CRC_EN];
   assign o_pin_pulldown_off = gen_q[`BLGC_BIT_PD_OFF];
   assign o_auto_ack = ack_w;
   assign o_pass_through = pass_w;
   assign o_crc_count_clear = crc_clr_q;
   assign o_fwd_check_override_enable = ov_en_w;
   // The value is gated so that a stale value cannot act without the enable.
   assign o_fwd_check_override_value = ov_val_w & ov_en_w;

   // Pixel clock presence comes from another domain, so it is synchronised.
   always @(posedge i_clk) begin
      if (i_srst) begin
         pres_meta_q <= 2'h0;
      end else begin
         pres_meta_q <= {pres_meta_q[0], i_pclk_present};
      end
   end
   assign o_use_always_on_clk = gen_q[`BLGC_BIT_CLK_AUTO] &&
      !pres_meta_q[1];

   // Sync pins cross in through two flops. A level is passed on only after
   // two consecutive enables have seen it, which costs two extra enables of
   // delay but rejects any pulse shorter than two pixel clocks.
   always @(posedge i_clk) begin
      if (i_srst) begin
         sync_meta_q <= 3'h0;
         sync_s_q <= 3'h0;
         sync_prev_q <= 3'h0;
         sync_stable_q <= 3'h0;
      end else begin
         sync_meta_q <= i_sync;
         sync_s_q <= sync_meta_q;
         if (i_pclk_en) begin
            sync_prev_q <= sync_s_q;
            sync_stable_q <= ~(sync_s_q ^ sync_prev_q);
         end
      end
   end

   generate
      for (gv_sync = 0; gv_sync < 3; gv_sync = gv_sync + 1) begin : g_sync
         // With the filter bit set, hold the output unless the last two samples agree; with it clear, pass the sample straight on.
         assign sync_d[gv_sync] = !gen_q[`BLGC_BIT_FILTER] ?
            sync_s_q[gv_sync] :
            (sync_stable_q[gv_sync] ? sync_prev_q[gv_sync] : o_sync[gv_sync]);
      end
   endgenerate

   always @(posedge i_clk) begin
      if (i_srst) begin
         o_sync <= 3'h0;
      end else if (i_pclk_en) begin
         o_sync <= sync_d;
      end
   end

endmodule // blgc_config

// ===== src/blgc_regs.vh
// Register offsets, field positions and reset values of the bridge config bank.
// Behaviour
// - Bit 6 swaps port B clock polarity.
// - Bit 5 swaps port B data polarity.
// - Bit 4 reverses port B lane order.
// - Bit 2 swaps port A clock polarity.
// - Bit 1 swaps port A data polarity.
// - Bit 0 reverses port A lane order.
// - General bit 7 enables CRC checker.
// - General bit 6 disables pin pull-downs.
// - General bit 5 auto-acknowledges remote writes.
// - General bit 4 filters short sync pulses.
// - General bit 3 enables I2C pass-through.
// - General bit 1 enables clock fallback.
// - Link select steers per-link field copies.
// - Config-two bit 5 holds CRC counters cleared.
// - Config-two bit 1 enables forward-check override.
// - Resets: general 92h, others zero.
// - Config-two bit 0 is override value.
// - Registers reached by host over I2C.
`ifndef BLGC_REGS_VH
`define BLGC_REGS_VH
`define BLGC_ADDR_LANE       8'h02
`define BLGC_ADDR_GEN        8'h03
`define BLGC_ADDR_GEN2       8'h04
`define BLGC_RST_LANE        8'h00
`define BLGC_RST_GEN         8'h92
`define BLGC_RST_GEN2        8'h00
`define BLGC_MASK_LANE       8'h77
`define BLGC_MASK_GEN        8'hd2
`define BLGC_MASK_GEN2       8'h23
`define BLGC_BIT_B_CLK_SWAP  6
`define BLGC_BIT_B_DATA_SWAP 5
`define BLGC_BIT_B_FLIP      4
`define BLGC_BIT_A_CLK_SWAP  2
`define BLGC_BIT_A_DATA_SWAP 1
`define BLGC_BIT_A_FLIP      0
`define BLGC_BIT_CRC_EN      7
`define BLGC_BIT_PD_OFF      6
`define BLGC_BIT_AUTO_ACK    5
`define BLGC_BIT_FILTER      4
`define BLGC_BIT_PASS        3
`define BLGC_BIT_CLK_AUTO    1
`define BLGC_BIT_CRC_CLR     5
`define BLGC_BIT_OV_EN       1
`define BLGC_BIT_OV_VAL      0
`endif

// ===== tb/blgc_assertions.sv
// Concurrent checks on the ports of the bridge configuration bank.
`timescale 1ns/1ns
`include "blgc_regs.vh"
module blgc_assertions (
   input wire       i_clk, i_srst, i_reg_wr, i_second_link_select,
   input wire [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
   input wire [3:0] i_a_data_p, i_a_data_n, o_a_data_p,
   input wire [3:0] i_b_data_p, i_b_data_n, o_b_data_p,
   input wire       i_a_clk_p, i_a_clk_n, o_a_clk_p,
   input wire       i_b_clk_p, i_b_clk_n, o_b_clk_p,
   input wire [3:0] o_a_data_n, o_b_data_n,
   input wire       o_a_clk_n, o_b_clk_n,
   input wire       o_crc_check_enable, o_pin_pulldown_off, o_crc_count_clear,
   input wire [1:0] o_auto_ack, o_pass_through,
   input wire [1:0] o_fwd_check_override_enable, o_fwd_check_override_value
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   wire       lane  = i_reg_addr == `BLGC_ADDR_LANE;
   wire       gen_w = i_reg_wr && i_reg_addr == `BLGC_ADDR_GEN;
   wire [3:0] ap    = o_reg_rdata[1] ? i_a_data_n : i_a_data_p;
   wire [3:0] bp    = o_reg_rdata[5] ? i_b_data_n : i_b_data_p;
   wire [3:0] an    = o_reg_rdata[1] ? i_a_data_p : i_a_data_n;
   wire [3:0] bn    = o_reg_rdata[5] ? i_b_data_p : i_b_data_n;
   function automatic [3:0] rv(input [3:0] x);
      rv = {x[0], x[1], x[2], x[3]};
   endfunction
   a_clk_swaps: assert property (lane |->
      o_a_clk_p == (o_reg_rdata[2] ? i_a_clk_n : i_a_clk_p) &&
      o_b_clk_p == (o_reg_rdata[6] ? i_b_clk_n : i_b_clk_p)) else $error("clk");
   a_data_map_a: assert property (lane |->
      o_a_data_p == (o_reg_rdata[0] ? rv(ap) : ap)) else $error("map A");
   a_data_map_b: assert property (lane |->
      o_b_data_p == (o_reg_rdata[4] ? rv(bp) : bp)) else $error("map B");
   a_n_legs_map: assert property (lane |->
      o_a_data_n == (o_reg_rdata[0] ? rv(an) : an) &&
      o_b_data_n == (o_reg_rdata[4] ? rv(bn) : bn) &&
      o_a_clk_n == (o_reg_rdata[2] ? i_a_clk_p : i_a_clk_n) &&
      o_b_clk_n == (o_reg_rdata[6] ? i_b_clk_p : i_b_clk_n))
      else $error("n legs");
   a_general_write: assert property (gen_w |=>
      o_crc_check_enable == $past(i_reg_wdata[7]) &&
      o_pin_pulldown_off == $past(i_reg_wdata[6])) else $error("general");
   a_link_steer: assert property (gen_w && i_second_link_select |=>
      o_auto_ack[1] == $past(i_reg_wdata[5]) && $stable(o_auto_ack[0]) &&
      o_pass_through[1] == $past(i_reg_wdata[3])) else $error("steer");
   a_reset_value: assert property (disable iff (1'b0) i_srst |=>
      o_crc_check_enable && !o_pin_pulldown_off && o_auto_ack == 2'b00 &&
      !o_crc_count_clear) else $error("reset");
   a_count_clear: assert property (i_reg_wr &&
      i_reg_addr == `BLGC_ADDR_GEN2 |=> o_crc_count_clear ==
      $past(i_reg_wdata[5])) else $error("clear");
   a_reserved_zero: assert property (i_reg_addr == `BLGC_ADDR_GEN |->
      (o_reg_rdata & ~(`BLGC_MASK_GEN | 8'h28)) == 8'h00)
      else $error("reserved");
   a_override_gate: assert property (i_reg_wr &&
      i_reg_addr == `BLGC_ADDR_GEN2 && !i_second_link_select |=>
      o_fwd_check_override_enable[0] == $past(i_reg_wdata[1]) &&
      o_fwd_check_override_value[0] ==
      ($past(i_reg_wdata[1]) && $past(i_reg_wdata[0])))
      else $error("override");
   cover property (gen_w && i_second_link_select);
   cover property (lane && o_reg_rdata[4] && o_reg_rdata[0]);
   cover property ($rose(o_crc_count_clear));
endmodule // blgc_assertions
bind blgc_config blgc_assertions u_chk (.i_clk(i_clk), .i_srst(i_srst),
   .i_reg_wr(i_reg_wr), .i_second_link_select(i_second_link_select),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata), .i_a_data_p(i_a_data_p),
   .i_a_data_n(i_a_data_n), .o_a_data_p(o_a_data_p),
   .i_b_data_p(i_b_data_p), .i_b_data_n(i_b_data_n),
   .o_b_data_p(o_b_data_p), .i_a_clk_p(i_a_clk_p), .i_a_clk_n(i_a_clk_n),
   .o_a_clk_p(o_a_clk_p), .i_b_clk_p(i_b_clk_p), .i_b_clk_n(i_b_clk_n),
   .o_b_clk_p(o_b_clk_p), .o_a_data_n(o_a_data_n),
   .o_b_data_n(o_b_data_n), .o_a_clk_n(o_a_clk_n), .o_b_clk_n(o_b_clk_n),
   .o_crc_check_enable(o_crc_check_enable),
   .o_pin_pulldown_off(o_pin_pulldown_off),
   .o_crc_count_clear(o_crc_count_clear), .o_auto_ack(o_auto_ack),
   .o_pass_through(o_pass_through),
   .o_fwd_check_override_enable(o_fwd_check_override_enable),
   .o_fwd_check_override_value(o_fwd_check_override_value));

// ===== tb/blgc_partner.sv
// Far-side video source driving the lane pairs of both ports.
`timescale 1ns/1ns
module blgc_partner (
   input  wire       i_clk,
   output reg  [3:0] o_dp,
   output wire [3:0] o_dn,
   output wire       o_cp,
   output wire       o_cn
);
   // The pattern moves every cycle and n is not simply ~p, so a swap shows.
   initial o_dp = 4'h0;
   always @(posedge i_clk) o_dp <= #5 o_dp + 4'h3;
   assign o_dn = o_dp + 4'h9;
   assign o_cp = o_dp[0];
   assign o_cn = o_dp[1];
endmodule // blgc_partner

// ===== tb/bridge_lane_and_general_config_test.sv
// Self-checking bench for the bridge configuration bank.
`timescale 1ns/1ns
`include "blgc_regs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: %h %h", $time, g, e); end end
module bridge_lane_and_general_config_test;
   typedef struct {logic [7:0] a, d; logic s; logic [7:0] e;} blgc_row_t;
   reg        i_clk = 1'b0, i_srst = 1'b1, i_reg_wr = 1'b0, i_sel = 1'b0;
   reg  [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
   reg        pres = 1'b0;
   reg  [2:0] i_sync = 3'h0;
   wire [7:0] rdata;
   wire [3:0] dp, dn, oap;
   wire [2:0] o_sync;
   wire [1:0] ack;
   wire       cp, cn, obcp, aon;
   int        bad_count = 0, n_tests = 0, i;
   blgc_row_t rows [6] = '{'{8'h02, 8'hff, 1'b0, 8'h77},
      '{8'h03, 8'hff, 1'b0, 8'hfa}, '{8'h03, 8'h00, 1'b1, 8'h00},
      '{8'h04, 8'hff, 1'b0, 8'h23}, '{8'h04, 8'h00, 1'b1, 8'h00},
      '{8'h05, 8'hff, 1'b0, 8'h00}};
   blgc_partner u_src (.i_clk(i_clk), .o_dp(dp), .o_dn(dn), .o_cp(cp),
      .o_cn(cn));
   blgc_config dut (.i_clk(i_clk), .i_srst(i_srst), .i_reg_wr(i_reg_wr),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_second_link_select(i_sel), .o_reg_rdata(rdata),
      .i_a_data_p(dp), .i_a_data_n(dn), .i_a_clk_p(cp), .i_a_clk_n(cn),
      .o_a_data_p(oap), .o_a_data_n(), .o_a_clk_p(), .o_a_clk_n(),
      .i_b_data_p(dp), .i_b_data_n(dn), .i_b_clk_p(cp), .i_b_clk_n(cn),
      .o_b_data_p(), .o_b_data_n(), .o_b_clk_p(obcp), .o_b_clk_n(),
      .i_pclk_en(1'b1), .i_sync(i_sync), .o_sync(o_sync),
      .i_pclk_present(pres), .o_use_always_on_clk(aon),
      .o_crc_check_enable(), .o_pin_pulldown_off(), .o_auto_ack(ack),
      .o_pass_through(), .o_crc_count_clear(),
      .o_fwd_check_override_enable(), .o_fwd_check_override_value());
   initial forever #25 i_clk = ~i_clk;
   task automatic wr(input [7:0] a, d, input s);
      @(posedge i_clk);
      #5 {i_reg_wr, i_reg_addr, i_reg_wdata, i_sel} = {1'b1, a, d, s};
      @(posedge i_clk);
      #5 i_reg_wr = 1'b0;
   endtask
   task automatic rd(input [7:0] a, input s, input [7:0] e);
      #1 {i_reg_addr, i_sel} = {a, s};
      #1 `CHK(rdata, e)
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #5;
   endtask
   task report_and_stop;
      $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      report_and_stop;
   end
   initial begin
      tick(5);
      i_srst = 1'b0;
      tick(3);
      `CHK(aon, 1'b1)
      pres = 1'b1;
      tick(4);
      `CHK(aon, 1'b0)
      // A one-cycle pulse must die in the filter; a long one gets through.
      i_sync = 3'h7;
      tick(1);
      i_sync = 3'h0;
      for (i = 0; i < 6; i++) begin
         tick(1);
         `CHK(o_sync, 3'h0)
      end
      i_sync = 3'h7;
      for (i = 0; i < 8 && o_sync !== 3'h7; i++) tick(1);
      `CHK(o_sync, 3'h7)
      for (i = 0; i < 6; i++) begin
         wr(rows[i].a, rows[i].d, rows[i].s);
         rd(rows[i].a, rows[i].s, rows[i].e);
      end
      rd(`BLGC_ADDR_GEN, 1'b0, 8'h28);
      // The filter is off now; i_sync is still high from the long pulse, so o_sync is already 7 when checked.
      i_sync = 3'h7;
      tick(1);
      i_sync = 3'h0;
      for (i = 0; i < 6 && o_sync !== 3'h7; i++) tick(1);
      `CHK(o_sync, 3'h7)
      tick(4);
      `CHK(ack, 2'b01)
      rd(`BLGC_ADDR_GEN2, 1'b0, 8'h03);
      `CHK(oap, {dn[0], dn[1], dn[2], dn[3]})
      `CHK(obcp, cn)
      pres = 1'b0;
      tick(4);
      `CHK(aon, 1'b0)
      i_srst = 1'b1;
      tick(1);
      i_srst = 1'b0;
      rd(`BLGC_ADDR_LANE, 1'b0, 8'h00);
      rd(`BLGC_ADDR_GEN, 1'b1, 8'h92);
      rd(`BLGC_ADDR_GEN2, 1'b0, 8'h00);
      report_and_stop;
   end
endmodule // bridge_lane_and_general_config_test
